// [src/herc_defs.svh]
`ifndef HERC_DEFS_SVH
`define HERC_DEFS_SVH
// ==========================================
// register map
`define HERC_CTRL_OFS 8'hc0
`define HERC_CAP_OFS 8'hb4
`define HERC_CTRL_RST 32'h0000_0010
`define HERC_CTRL_WMASK 32'h0000_3fdd
`define HERC_ALL_ONES 64'hffff_ffff_ffff_ffff
// ==========================================
// control bit positions
`define HERC_B_HARDFAIL 13
`define HERC_B_MABORT 12
`define HERC_B_ECC_RPT 11
`define HERC_B_ECC_COR 10
`define HERC_B_TO_RPT 9
`define HERC_B_WDOG 8
`define HERC_B_ADDRESS_ERROR_SIGNAL_SERR 7
`define HERC_B_BUS_ERROR_SIGNAL_SERR 6
`define HERC_B_BUS_ERROR_SIGNAL_BUS_INITIALIZE_SIGNAL 4
`define HERC_B_PROT_BUS_INITIALIZE_SIGNAL 3
`define HERC_B_BUS_ERROR_SIGNAL_OUT 2
`define HERC_B_ADDRESS_ERROR_SIGNAL_OUT 0
// ==========================================
// captured configuration bit positions
`define HERC_CAP_BUS_INITIALIZE_SIGNAL 10
`define HERC_CAP_BUS_ERROR_SIGNAL 9
`define HERC_CAP_ADDRESS_ERROR_SIGNAL 8
// ==========================================
// watchdog times at 25 MHz
`define HERC_CLK_MHZ 25
`define HERC_WD_SHORT_US 1500
`define HERC_WD_LONG_US 30000
`define HERC_WD_SHORT_CYC (`HERC_WD_SHORT_US * `HERC_CLK_MHZ)
`define HERC_WD_LONG_CYC (`HERC_WD_LONG_US * `HERC_CLK_MHZ)
`endif

// [src/herc_pkg.sv]
package herc_pkg;
    typedef enum logic [1:0] {
        HERC_WD_IDLE,
        HERC_WD_RUN,
        HERC_WD_FIRE
    } herc_wd_t;
endpackage

// [src/herc_ctrl.sv]
`timescale 1ns/1ns
`include "herc_defs.svh"
// Contract
// - bit 13 set: report via hard-fail; clear: report via SERR#.
// - PCI data parity errors never go out as hard-fail.
// - bit 12: master-abort reads reported on bit 13 path, return all ones.
// - received-master-abort status flag set on every master abort.
// - bit 11 with bit 2: uncorrectable ECC error asserts bus error signal.
// - bit 10 enables single-bit ECC correction; otherwise none.
// - bit 9: time-outs reported on bit 13 path; clear: not reported.
// - reads hit by a time-out return all ones.
// - time-out status flag set on every time-out regardless of reporting.
// - bit 8 runs watchdog 1.5 ms or 30 ms; expiry answers transaction.
// - watchdog enable acts only in the compatibility bridge.
// - address error to SERR# needs bit 7, captured enable, SERR# enable.
// - bus error to SERR# needs bit 6 and captured bus-error enable.
// - bit 4: bus error signal causes bus-initialize assertion.
// - bit 3: protocol violation causes bus-initialize assertion.
// - bit 2: host bus errors assert bus error signal; else not driven.
// - bit 0: request-phase parity errors assert address error signal.
// - bits 31:14, 5 and 1 have no function and read zero.
// - captured enables latch from address lines at reset release, read-only.
module herc_ctrl
    import herc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    input wire logic [2:0] host_addr_strap_in,
    input wire logic compat_bridge_in,
    input wire logic wd_long_sel_in,
    input wire logic serr_cmd_en_in,
    input wire logic host_req_err_in,
    input wire logic pci_perr_in,
    input wire logic mabort_read_in,
    input wire logic mabort_in,
    input wire logic host_cycle_pending_in,
    input wire logic host_response_in,
    input wire logic ecc_single_in,
    input wire logic ecc_multi_in,
    input wire logic host_bus_err_in,
    input wire logic prot_violation_in,
    input wire logic req_parity_err_in,
    input wire logic address_error_signal_b_in,
    input wire logic bus_error_signal_b_in,
    output logic address_error_signal_b_out,
    output logic address_error_signal_oe_b_out,
    output logic bus_error_signal_b_out,
    output logic bus_error_signal_oe_b_out,
    output logic bus_initialize_signal_b_out,
    output logic bus_initialize_signal_oe_b_out,
    output logic serr_b_out,
    output logic hard_fail_out,
    output logic read_all_ones_out,
    output logic wd_timeout_out,
    output logic ecc_correct_en_out,
    output logic rcv_mabort_set_out,
    output logic timeout_flag_set_out,
    output logic [2:0] captured_en_out
);
    // ==========================================
    // pin synchronisers
    logic address_error_signal_s1_q, address_error_signal_s2_q, bus_error_signal_s1_q, bus_error_signal_s2_q;
    logic rst_seen_q;
    logic [2:0] strap_s1_q, strap_s2_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            address_error_signal_s1_q <= 1'b1;
            address_error_signal_s2_q <= 1'b1;
            bus_error_signal_s1_q <= 1'b1;
            bus_error_signal_s2_q <= 1'b1;
        end else begin
            address_error_signal_s1_q <= address_error_signal_b_in;
            address_error_signal_s2_q <= address_error_signal_s1_q;
            bus_error_signal_s1_q <= bus_error_signal_b_in;
            bus_error_signal_s2_q <= bus_error_signal_s1_q;
        end
    end
    // straps run free through reset so capture sees settled levels
    always_ff @(posedge clk_in) begin
        strap_s1_q <= host_addr_strap_in;
        strap_s2_q <= strap_s1_q;
    end
    wire address_error_signal_seen = !address_error_signal_s2_q;
    wire bus_error_signal_seen = !bus_error_signal_s2_q;

    // ==========================================
    // captured configuration values
    logic [2:0] cap_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_seen_q <= 1'b0;
            cap_q <= 3'h0;
        end else if (!rst_seen_q) begin
            rst_seen_q <= 1'b1;
            cap_q <= strap_s2_q;
        end
    end
    // cap_q: [0]=addr err, [1]=bus err, [2]=bus init input enables
    wire cap_address_error_signal = cap_q[0];
    wire cap_bus_error_signal = cap_q[1];
    wire [31:0] cap_word = ({31'h0, cap_q[2]} << `HERC_CAP_BUS_INITIALIZE_SIGNAL)
        | ({31'h0, cap_q[1]} << `HERC_CAP_BUS_ERROR_SIGNAL)
        | ({31'h0, cap_q[0]} << `HERC_CAP_ADDRESS_ERROR_SIGNAL);

    // ==========================================
    // control register
    logic [31:0] ctrl_q, ctrl_d;
    wire ctrl_hit = cfg_wr_in && (cfg_addr_in == `HERC_CTRL_OFS);
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_hit)
            ctrl_d = cfg_wdata_in & `HERC_CTRL_WMASK;
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            ctrl_q <= `HERC_CTRL_RST;
        else
            ctrl_q <= ctrl_d;
    end
    wire en_hardfail = ctrl_q[`HERC_B_HARDFAIL];
    wire en_mabort = ctrl_q[`HERC_B_MABORT];
    wire en_ecc_rpt = ctrl_q[`HERC_B_ECC_RPT];
    wire en_ecc_cor = ctrl_q[`HERC_B_ECC_COR];
    wire en_to_rpt = ctrl_q[`HERC_B_TO_RPT];
    wire en_wdog = ctrl_q[`HERC_B_WDOG] && compat_bridge_in;
    wire en_address_error_signal_serr = ctrl_q[`HERC_B_ADDRESS_ERROR_SIGNAL_SERR];
    wire en_bus_error_signal_serr = ctrl_q[`HERC_B_BUS_ERROR_SIGNAL_SERR];
    wire en_bus_error_signal_bus_initialize_signal = ctrl_q[`HERC_B_BUS_ERROR_SIGNAL_BUS_INITIALIZE_SIGNAL];
    wire en_prot_bus_initialize_signal = ctrl_q[`HERC_B_PROT_BUS_INITIALIZE_SIGNAL];
    wire en_bus_error_signal_out = ctrl_q[`HERC_B_BUS_ERROR_SIGNAL_OUT];
    wire en_address_error_signal_out = ctrl_q[`HERC_B_ADDRESS_ERROR_SIGNAL_OUT];

    // ==========================================
    // bus watchdog
    localparam int WD_SHORT = `HERC_WD_SHORT_CYC;
    localparam int WD_LONG = `HERC_WD_LONG_CYC;
    herc_wd_t wd_q, wd_d;
    logic [19:0] wd_cnt_q, wd_cnt_d;
    wire [19:0] wd_limit = wd_long_sel_in ? 20'(WD_LONG - 1)
        : 20'(WD_SHORT - 1);
    wire wd_expire = (wd_cnt_q >= wd_limit);
    always_comb begin
        wd_d = wd_q;
        wd_cnt_d = wd_cnt_q;
        case (wd_q)
            HERC_WD_IDLE: begin
                wd_cnt_d = 20'h0_0000;
                if (en_wdog && host_cycle_pending_in)
                    wd_d = HERC_WD_RUN;
            end
            HERC_WD_RUN: begin
                wd_cnt_d = wd_cnt_q + 20'h0_0001;
                if (!en_wdog || host_response_in || !host_cycle_pending_in)
                    wd_d = HERC_WD_IDLE;
                else if (wd_expire)
                    wd_d = HERC_WD_FIRE;
            end
            HERC_WD_FIRE: wd_d = HERC_WD_IDLE;
            default: wd_d = HERC_WD_IDLE;
        endcase
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wd_q <= HERC_WD_IDLE;
            wd_cnt_q <= 20'h0_0000;
        end else begin
            wd_q <= wd_d;
            wd_cnt_q <= wd_cnt_d;
        end
    end
    wire timeout = (wd_q == HERC_WD_FIRE);

    // ==========================================
    // error routing
    wire ecc_to_bus_error_signal = ecc_multi_in && en_ecc_rpt && en_bus_error_signal_out;
    wire drive_bus_error_signal = (host_bus_err_in && en_bus_error_signal_out) || ecc_to_bus_error_signal;
    wire drive_address_error_signal = req_parity_err_in && en_address_error_signal_out;
    wire drive_bus_initialize_signal = (bus_error_signal_seen && en_bus_error_signal_bus_initialize_signal)
        || (prot_violation_in && en_prot_bus_initialize_signal);
    wire path_err = host_req_err_in
        || (mabort_read_in && en_mabort)
        || (timeout && en_to_rpt);
    wire hf_d = path_err && en_hardfail;
    // parity errors go only to SERR#
    wire serr_perr = pci_perr_in && serr_cmd_en_in;
    wire serr_path = path_err && !en_hardfail && serr_cmd_en_in;
    wire serr_address_error_signal = address_error_signal_seen && en_address_error_signal_serr && cap_address_error_signal
        && serr_cmd_en_in;
    wire serr_bus_error_signal = bus_error_signal_seen && en_bus_error_signal_serr && cap_bus_error_signal;
    wire serr_d = serr_perr || serr_path || serr_address_error_signal || serr_bus_error_signal;
    wire ones_d = mabort_read_in || timeout;
    wire [31:0] rdata_d = (cfg_addr_in == `HERC_CTRL_OFS) ? ctrl_q
        : (cfg_addr_in == `HERC_CAP_OFS) ? cap_word : 32'h0000_0000;

    // ==========================================
    // registered outputs
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            address_error_signal_b_out <= 1'b1;
            address_error_signal_oe_b_out <= 1'b1;
            bus_error_signal_b_out <= 1'b1;
            bus_error_signal_oe_b_out <= 1'b1;
            bus_initialize_signal_b_out <= 1'b1;
            bus_initialize_signal_oe_b_out <= 1'b1;
            serr_b_out <= 1'b1;
            hard_fail_out <= 1'b0;
            read_all_ones_out <= 1'b0;
            wd_timeout_out <= 1'b0;
            ecc_correct_en_out <= 1'b0;
            rcv_mabort_set_out <= 1'b0;
            timeout_flag_set_out <= 1'b0;
            captured_en_out <= 3'h0;
            cfg_rdata_out <= 32'h0000_0000;
        end else begin
            address_error_signal_b_out <= !drive_address_error_signal;
            address_error_signal_oe_b_out <= !drive_address_error_signal;
            bus_error_signal_b_out <= !drive_bus_error_signal;
            bus_error_signal_oe_b_out <= !drive_bus_error_signal;
            bus_initialize_signal_b_out <= !drive_bus_initialize_signal;
            bus_initialize_signal_oe_b_out <= !drive_bus_initialize_signal;
            serr_b_out <= !serr_d;
            hard_fail_out <= hf_d;
            read_all_ones_out <= ones_d;
            wd_timeout_out <= timeout;
            ecc_correct_en_out <= en_ecc_cor;
            rcv_mabort_set_out <= mabort_in;
            timeout_flag_set_out <= timeout;
            captured_en_out <= cap_q;
            cfg_rdata_out <= rdata_d;
        end
    end

    // ==========================================
    // assertions
    AST_RESET_DEFAULT: assert property (@(posedge clk_in)
        $rose(rst_b_in) |-> ctrl_q == `HERC_CTRL_RST)
        else $error("control default wrong after reset");
    AST_RSVD_ZERO: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) (ctrl_q & ~`HERC_CTRL_WMASK) == 32'h0)
        else $error("reserved control bits not zero");
    AST_HF_SELECT: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) host_req_err_in && en_hardfail
        |=> hard_fail_out)
        else $error("hard fail missing");
    AST_SERR_PATH: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) path_err && !en_hardfail && serr_cmd_en_in
        |=> !serr_b_out && !hard_fail_out)
        else $error("serr path not taken");
    AST_MABORT_HF: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) mabort_read_in && en_mabort && en_hardfail
        |=> hard_fail_out)
        else $error("master abort not reported by hard fail");
    AST_MABORT_OFF: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) mabort_read_in && !en_mabort
        && !host_req_err_in && !timeout |=> !hard_fail_out)
        else $error("master abort reported while disabled");
    AST_ECC_BUS_ERROR_SIGNAL: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) ecc_multi_in && en_ecc_rpt && en_bus_error_signal_out
        |=> !bus_error_signal_b_out && !bus_error_signal_oe_b_out)
        else $error("ecc error not on bus error signal");
    AST_ECC_COR_ON: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) en_ecc_cor |=> ecc_correct_en_out)
        else $error("ecc correction not enabled");
    AST_ECC_COR_OFF: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !en_ecc_cor |=> !ecc_correct_en_out)
        else $error("ecc correction enabled while off");
    AST_TO_RPT_OFF: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) timeout && !en_to_rpt && !host_req_err_in
        && !mabort_read_in |=> !hard_fail_out)
        else $error("timeout reported while disabled");
    AST_TO_ONES: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) timeout |=> read_all_ones_out)
        else $error("timeout read not all ones");
    AST_WD_IDLE: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !en_wdog |=> wd_q == HERC_WD_IDLE)
        else $error("watchdog ran while disabled");
    AST_WD_PULSE: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) timeout |=> wd_timeout_out)
        else $error("watchdog expiry not shown");
    AST_PERR_NO_HF: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) pci_perr_in && !host_req_err_in
        && !mabort_read_in && !timeout |=> !hard_fail_out)
        else $error("parity error used hard fail");
    AST_MABORT_ONES: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) mabort_read_in |=> read_all_ones_out)
        else $error("master abort read not all ones");
    AST_MABORT_FLAG: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) mabort_in |=> rcv_mabort_set_out)
        else $error("master abort flag not set");
    AST_TO_FLAG: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) timeout |=> timeout_flag_set_out
        && read_all_ones_out)
        else $error("timeout flag or all ones missing");
    AST_WD_OFF: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !compat_bridge_in |=> ##1 !timeout)
        else $error("watchdog ran in auxiliary bridge");
    AST_BUS_INITIALIZE_SIGNAL_BUS_ERROR_SIGNAL: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) bus_error_signal_seen && en_bus_error_signal_bus_initialize_signal
        |=> !bus_initialize_signal_b_out && !bus_initialize_signal_oe_b_out)
        else $error("bus init not driven on bus error");
    AST_BUS_INITIALIZE_SIGNAL_QUIET: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !en_bus_error_signal_bus_initialize_signal && !en_prot_bus_initialize_signal
        |=> bus_initialize_signal_oe_b_out)
        else $error("bus init driven while disabled");
    AST_PROT_BUS_INITIALIZE_SIGNAL: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) prot_violation_in && en_prot_bus_initialize_signal
        |=> !bus_initialize_signal_b_out && !bus_initialize_signal_oe_b_out)
        else $error("bus init not driven on protocol violation");
    AST_BUS_ERROR_SIGNAL_SERR: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) bus_error_signal_seen && en_bus_error_signal_serr && cap_bus_error_signal
        |=> !serr_b_out)
        else $error("serr missing on bus error");
    AST_ADDRESS_ERROR_SIGNAL_SERR: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) address_error_signal_seen && !cap_address_error_signal && !serr_perr
        && !serr_path && !serr_bus_error_signal |=> serr_b_out)
        else $error("serr without captured enable");
    AST_BUS_ERROR_SIGNAL_OUT: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !en_bus_error_signal_out |=> bus_error_signal_oe_b_out)
        else $error("bus error driven while disabled");
    AST_BUS_ERROR_SIGNAL_DRIVE: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) host_bus_err_in && en_bus_error_signal_out
        |=> !bus_error_signal_b_out && !bus_error_signal_oe_b_out)
        else $error("bus error not driven");
    AST_ADDRESS_ERROR_SIGNAL_DRIVE: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) req_parity_err_in && en_address_error_signal_out
        |=> !address_error_signal_b_out && !address_error_signal_oe_b_out)
        else $error("address error not driven");
    AST_ADDRESS_ERROR_SIGNAL_QUIET: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) !en_address_error_signal_out |=> address_error_signal_oe_b_out)
        else $error("address error driven while disabled");
    AST_CAP_HOLD: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) rst_seen_q |=> $stable(cap_q))
        else $error("captured enables changed");
    AST_RDATA: assert property (@(posedge clk_in)
        disable iff (!rst_b_in) cfg_addr_in == `HERC_CTRL_OFS
        |=> cfg_rdata_out == $past(ctrl_q))
        else $error("control read data wrong");
    COV_HF: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        hard_fail_out);
    COV_WD: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        wd_timeout_out);
    COV_SERR: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        !serr_b_out);
    COV_ECC_FIX: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        ecc_single_in && ecc_correct_en_out);
    COV_BUS_INITIALIZE_SIGNAL: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        !bus_initialize_signal_b_out);
endmodule

// [verification/herc_host_model.sv]
`timescale 1ns/1ns
// ==========================================
// other host agents on the shared error pins
module herc_host_model (
    input wire logic agent_address_error_signal_in,
    input wire logic agent_bus_error_signal_in,
    input wire logic address_error_signal_b_in,
    input wire logic address_error_signal_oe_b_in,
    input wire logic bus_error_signal_b_in,
    input wire logic bus_error_signal_oe_b_in,
    output logic address_error_signal_wire_b_out,
    output logic bus_error_signal_wire_b_out
);
    // pulled up: low whenever any party drives low
    assign address_error_signal_wire_b_out = ~(agent_address_error_signal_in | (~address_error_signal_oe_b_in & ~address_error_signal_b_in));
    assign bus_error_signal_wire_b_out = ~(agent_bus_error_signal_in | (~bus_error_signal_oe_b_in & ~bus_error_signal_b_in));
endmodule

// [verification/tb_host_bus_error_report_control.sv]
`timescale 1ns/1ns
module tb_host_bus_error_report_control;
    import herc_pkg::*;
    logic clk_in = 0, rst_b_in = 0, cfg_wr_in = 0, compat_bridge_in = 0;
    logic serr_cmd_en_in = 0, host_cycle_pending_in = 0, ag_address_error_signal = 0;
    logic ag_bus_error_signal = 0, address_error_signal_w_b, bus_error_signal_w_b;
    logic [7:0] cfg_addr_in = 0;
    logic [31:0] cfg_wdata_in = 0, cfg_rdata_out;
    logic [2:0] host_addr_strap_in = 3'b111, captured_en_out;
    logic [8:0] ev = 0;
    logic address_error_signal_b_out, address_error_signal_oe_b_out, bus_error_signal_b_out, bus_error_signal_oe_b_out, bus_initialize_signal_b_out;
    logic bus_initialize_signal_oe_b_out, serr_b_out, hard_fail_out, read_all_ones_out;
    logic wd_timeout_out, ecc_correct_en_out, rcv_mabort_set_out;
    logic timeout_flag_set_out;
    int err_total = 0, checks_done = 0, n;

    herc_ctrl dut (.clk_in, .rst_b_in, .cfg_wr_in, .cfg_addr_in,
        .cfg_wdata_in, .cfg_rdata_out, .host_addr_strap_in, .compat_bridge_in,
        .wd_long_sel_in(1'b0), .serr_cmd_en_in, .host_req_err_in(ev[0]),
        .pci_perr_in(ev[1]), .mabort_read_in(ev[2]), .mabort_in(ev[3]),
        .host_cycle_pending_in, .host_response_in(1'b0),
        .ecc_single_in(ev[4]), .ecc_multi_in(ev[5]),
        .host_bus_err_in(ev[6]), .prot_violation_in(ev[7]),
        .req_parity_err_in(ev[8]), .address_error_signal_b_in(address_error_signal_w_b), .bus_error_signal_b_in(bus_error_signal_w_b),
        .address_error_signal_b_out, .address_error_signal_oe_b_out, .bus_error_signal_b_out, .bus_error_signal_oe_b_out,
        .bus_initialize_signal_b_out, .bus_initialize_signal_oe_b_out, .serr_b_out, .hard_fail_out,
        .read_all_ones_out, .wd_timeout_out, .ecc_correct_en_out,
        .rcv_mabort_set_out, .timeout_flag_set_out, .captured_en_out);
    herc_host_model agents (.agent_address_error_signal_in(ag_address_error_signal), .agent_bus_error_signal_in(ag_bus_error_signal),
        .address_error_signal_b_in(address_error_signal_b_out), .address_error_signal_oe_b_in(address_error_signal_oe_b_out),
        .bus_error_signal_b_in(bus_error_signal_b_out), .bus_error_signal_oe_b_in(bus_error_signal_oe_b_out),
        .address_error_signal_wire_b_out(address_error_signal_w_b), .bus_error_signal_wire_b_out(bus_error_signal_w_b));

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    // ==========================================
    // access and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_in);
        cfg_wr_in = 1'b1;
        cfg_addr_in = a;
        cfg_wdata_in = d;
        @(negedge clk_in);
        cfg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk_in);
        cfg_addr_in = a;
        @(negedge clk_in);
        chk(cfg_rdata_out, exp);
    endtask
    // one-cycle event pulse, outputs settled on return
    task automatic fire(input logic [8:0] m);
        @(negedge clk_in);
        ev = m;
        @(negedge clk_in);
        ev = 9'h000;
    endtask
    // agent pin levels held past the two-flop sync
    task automatic pin(input logic a, input logic b);
        ag_address_error_signal = a;
        ag_bus_error_signal = b;
        repeat (4) @(negedge clk_in);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rd(8'hc0, 32'h0000_0010);
        chk(captured_en_out, 3'b111);
        host_addr_strap_in = 3'b000;
        wr(8'hb4, 32'h0000_0000);
        rd(8'hb4, 32'h0000_0700);
        wr(8'hc0, 32'hffff_ffff);
        rd(8'hc0, 32'h0000_3fdd);
        chk(ecc_correct_en_out, 1'b1);
        wr(8'hc4, 32'h0000_0000);
        rd(8'hc4, 32'h0000_0000);
        rd(8'hc0, 32'h0000_3fdd);
        $display("test registers done");
        serr_cmd_en_in = 1'b1;
        wr(8'hc0, 32'h0000_2000);
        fire(9'h001);
        chk({hard_fail_out, serr_b_out}, 2'b11);
        fire(9'h002);
        chk({hard_fail_out, serr_b_out}, 2'b00);
        wr(8'hc0, 32'h0000_0000);
        chk(ecc_correct_en_out, 1'b0);
        fire(9'h001);
        chk({hard_fail_out, serr_b_out}, 2'b00);
        fire(9'h00c);
        chk({rcv_mabort_set_out, serr_b_out}, 2'b11);
        wr(8'hc0, 32'h0000_3000);
        fire(9'h00c);
        chk({hard_fail_out, read_all_ones_out}, 2'b11);
        $display("test reporting path done");
        wr(8'hc0, 32'h0000_0800);
        fire(9'h020);
        chk(bus_error_signal_oe_b_out, 1'b1);
        wr(8'hc0, 32'h0000_0804);
        fire(9'h020);
        chk({bus_error_signal_b_out, bus_error_signal_oe_b_out}, 2'b00);
        fire(9'h040);
        chk(bus_error_signal_oe_b_out, 1'b0);
        wr(8'hc0, 32'h0000_0009);
        fire(9'h040);
        chk(bus_error_signal_oe_b_out, 1'b1);
        fire(9'h080);
        chk({bus_initialize_signal_b_out, bus_initialize_signal_oe_b_out}, 2'b00);
        fire(9'h100);
        chk({address_error_signal_b_out, address_error_signal_oe_b_out}, 2'b00);
        $display("test bus signals done");
        wr(8'hc0, 32'h0000_0010);
        pin(1'b0, 1'b1);
        chk({bus_initialize_signal_b_out, serr_b_out}, 2'b01);
        pin(1'b0, 1'b0);
        wr(8'hc0, 32'h0000_0040);
        pin(1'b0, 1'b1);
        chk(serr_b_out, 1'b0);
        pin(1'b0, 1'b0);
        serr_cmd_en_in = 1'b0;
        wr(8'hc0, 32'h0000_0080);
        pin(1'b1, 1'b0);
        chk(serr_b_out, 1'b1);
        serr_cmd_en_in = 1'b1;
        pin(1'b1, 1'b0);
        chk(serr_b_out, 1'b0);
        pin(1'b0, 1'b0);
        $display("test pin reporting done");
        rst_b_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk(captured_en_out, 3'b000);
        rd(8'hc0, 32'h0000_0010);
        wr(8'hc0, 32'h0000_00c0);
        pin(1'b1, 1'b1);
        chk(serr_b_out, 1'b1);
        pin(1'b0, 1'b0);
        $display("test second reset done");
        wr(8'hc0, 32'h0000_0100);
        compat_bridge_in = 1'b1;
        host_cycle_pending_in = 1'b1;
        n = 0;
        while (n < 40000 && wd_timeout_out !== 1'b1) begin
            @(negedge clk_in);
            n++;
        end
        chk(n >= 37498 && n <= 37502, 1'b1);
        if (n >= 40000) begin
            report_and_stop();
        end
        host_cycle_pending_in = 1'b0;
        $display("test watchdog done");
        report_and_stop();
    end
endmodule
